//--- char_buf_pkg.sv
/*
 * Constants shared by the character/word buffer and its word FIFO:
 * pulse-time slots, instruction bit positions, widths and reset values.
 * Assumes one clock-enabled cycle per pulse time, Tp then T24 down to T0.
 */
package char_buf_pkg;
	// pulse-time slots, counted down once per pulse time
	localparam logic [4:0] SLOT_TP  = 5'h19;
	localparam logic [4:0] SLOT_T24 = 5'h18;
	localparam logic [4:0] SLOT_T22 = 5'h16;
	localparam logic [4:0] SLOT_T17 = 5'h11;
	localparam logic [4:0] SLOT_T5  = 5'h05;
	localparam logic [4:0] SLOT_T0  = 5'h00;
	// widths
	localparam int WORD_W     = 24;
	localparam int CHAR_W     = 6;
	localparam int UNIT_W     = 5;
	localparam int FIFO_DEPTH = 16;
	// instruction word bit positions, C0 is the leftmost bit
	localparam int C_CNT_LO  = 15;
	localparam int C_CNT_HI  = 16;
	localparam int C_SEL     = 17;
	localparam int C_DIR     = 18;
	localparam int C_UA_LO   = 19;
	localparam int C_UA_HI   = 23;
	localparam int CHAR_TOP  = 18;
	// reset values
	localparam logic [1:0]  CNT_RST  = 2'h0;
	localparam logic [4:0]  UNIT_RST = 5'h00;
	localparam logic [23:0] WORD_RST = 24'h00_0000;
	localparam logic [5:0]  CHAR_RST = 6'h00;

	// true while slot s lies in the span hi down to lo
	function automatic logic in_span(input logic [4:0] s,
		input logic [4:0] hi, input logic [4:0] lo);
		return (s <= hi) && (s >= lo);
	endfunction
endpackage

//--- word_fifo.sv
/*
 * Word FIFO with valid/ready on both sides and a registered head.
 * Assumes the filler honours in_ready and the drain may stall freely.
 */
`timescale 1ns/100ps
module word_fifo
	import char_buf_pkg::*;
#(
	parameter int W     = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;

	// the head register counts toward the depth, so at most DEPTH words wait
	assign in_ready = ((count_r + (AW+1)'(out_valid)) != FULL_CNT);
	assign push = in_valid && in_ready;
	assign pop = (count_r != '0) && (!out_valid || out_ready);

	// storage has no reset, only valid entries are ever read
	always_ff @(posedge clock) begin
		if (clk_en && push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// head register keeps the drain side straight from flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (clk_en) begin
			if (pop) begin
				out_valid <= 1'b1;
				out_data <= mem_r[rd_ptr_r];
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule

//--- char_word_buffer.sv
/*
 * Character/word buffer: assembles 6-bit link characters into 24-bit
 * words and splits words back into characters, paced by pulse times.
 * Assumes one clock-enabled cycle per pulse time, a start or transfer
 * command held by the processor until the buffer is done with it, and
 * a device character clock that arrives unsynchronised.
 */
`timescale 1ns/100ps
module char_word_buffer
	import char_buf_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               clk_en,
	input  wire logic               io_start_instr,
	input  wire logic [0:WORD_W-1]  instr_word,
	input  wire logic               word_transfer_cmd,
	input  wire logic [WORD_W-1:0]  c_in_word,
	input  wire logic               stop_cmd,
	input  wire logic               halt_detector,
	input  wire logic               char_clock,
	input  wire logic [CHAR_W-1:0]  char_in,
	input  wire logic               char_in_parity,
	input  wire logic               word_out_ready,
	output logic [CHAR_W-1:0]       char_out,
	output logic                    char_out_parity,
	output logic [WORD_W-1:0]       c_out_word,
	output logic                    xfer_done,
	output logic                    service_irq,
	output logic                    error_flag,
	output logic [UNIT_W-1:0]       unit_address,
	output logic                    direction_bit,
	output logic                    active_flag,
	output logic                    word_pending_flag,
	output logic                    word_out_valid,
	output logic [WORD_W-1:0]       word_out_data
);
	logic [4:0]        slot_r;
	logic [7:0]        pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
	logic              count_bit_lo_r, count_bit_hi_r;
	logic [1:0]        cnt;
	logic              precess_gate_r, cnt_phase_r;
	logic              precess_request_r, clock_seen_r;
	logic              xfer_hold_r;
	logic [WORD_W-1:0] word_assembly_reg_r;
	logic [1:0]        war_cnt_r;
	logic [CHAR_W-1:0] char_shift_reg_r;
	logic              parity_flop_r;
	logic              t0, t24, tp, span_clr, span_set;
	logic              buffer_clear_strobe, buffer_set_strobe;
	logic              prec, ecw, xfer_take, fifo_in_ready;
	logic [CHAR_W-1:0] zw;

	// pulse-time decode
	assign t0 = (slot_r == SLOT_T0);
	assign t24 = (slot_r == SLOT_T24);
	assign tp = (slot_r == SLOT_TP);
	assign span_clr = in_span(slot_r, SLOT_T22, SLOT_T17);
	assign span_set = in_span(slot_r, SLOT_T5, SLOT_T0);
	// start strobes for this buffer only
	assign buffer_clear_strobe = io_start_instr && !instr_word[C_SEL]
		&& span_clr;
	assign buffer_set_strobe = io_start_instr && !instr_word[C_SEL]
		&& span_set;
	assign prec = precess_gate_r && !cnt_phase_r;
	assign cnt = {count_bit_lo_r, count_bit_hi_r};
	assign ecw = pin_lvl_r[7];
	assign zw = pin_lvl_r[CHAR_W-1:0];
	// transfer waits for an idle word register and room for the word
	assign xfer_take = word_transfer_cmd && !word_pending_flag
		&& !precess_gate_r && !xfer_hold_r && t24
		&& (direction_bit || fifo_in_ready);

	assign char_out = char_shift_reg_r;
	assign char_out_parity = parity_flop_r;

	// pulse-time counter: Tp, T24 ... T0, then Tp again
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			slot_r <= SLOT_TP;
		end else if (clk_en) begin
			slot_r <= t0 ? SLOT_TP : slot_r - 5'h01;
		end
	end

	// pins: a bit moves only once the 2nd and 3rd stages agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1_r <= 8'h00;
			pin_s2_r <= 8'h00;
			pin_s3_r <= 8'h00;
			pin_lvl_r <= 8'h00;
		end else if (clk_en) begin
			pin_s1_r <= {char_clock, char_in_parity, char_in};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_lvl_r <= (pin_s2_r & pin_s3_r)
				| (pin_lvl_r & (pin_s2_r | pin_s3_r));
		end
	end

	// address, direction and character counter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			unit_address <= UNIT_RST;
			direction_bit <= 1'b0;
			{count_bit_lo_r, count_bit_hi_r} <= CNT_RST;
		end else if (clk_en) begin
			if (buffer_clear_strobe) begin
				unit_address <= UNIT_RST;
				direction_bit <= 1'b0;
				{count_bit_lo_r, count_bit_hi_r} <= CNT_RST;
			end else if (buffer_set_strobe) begin
				unit_address <= instr_word[C_UA_LO:C_UA_HI];
				direction_bit <= instr_word[C_DIR];
				count_bit_lo_r <= instr_word[C_CNT_LO];
				count_bit_hi_r <= instr_word[C_CNT_HI];
			end else if (prec && t0 && cnt != 2'h0) begin
				{count_bit_lo_r, count_bit_hi_r} <= cnt - 2'h1;
			end else if (xfer_take) begin
				{count_bit_lo_r, count_bit_hi_r} <= war_cnt_r;
			end
		end
	end

	// precess gate: two pulse times after start, or T23..T0 per char
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			precess_gate_r <= 1'b0;
			cnt_phase_r <= 1'b0;
		end else if (clk_en) begin
			if (buffer_set_strobe && t0) begin
				precess_gate_r <= 1'b1;
				cnt_phase_r <= 1'b1;
			end else if (t24) begin
				// start phase ends here; precession needs pending
				precess_gate_r <= precess_request_r
					&& word_pending_flag;
				cnt_phase_r <= 1'b0;
			end else if (prec && t0) begin
				precess_gate_r <= 1'b0;
			end
		end
	end

	// count field of the word, written only in the start phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			war_cnt_r <= CNT_RST;
		end else if (clk_en && cnt_phase_r && precess_gate_r) begin
			war_cnt_r <= cnt;
		end
	end

	// device clock detection then precess request
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clock_seen_r <= 1'b0;
			precess_request_r <= 1'b0;
		end else if (clk_en) begin
			if (buffer_clear_strobe) begin
				clock_seen_r <= 1'b0;
				precess_request_r <= 1'b0;
			end else begin
				if (precess_request_r && t0) begin
					clock_seen_r <= 1'b0;
				end else if (!precess_request_r && ecw && span_clr) begin
					clock_seen_r <= 1'b1;
				end
				if (prec && t0) begin
					precess_request_r <= 1'b0;
				end else if (!precess_request_r && clock_seen_r
					&& !ecw && t0) begin
					precess_request_r <= 1'b1;
				end
			end
		end
	end

	// word-pending flag; a transfer setting it wins over the clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			word_pending_flag <= 1'b0;
		end else if (clk_en) begin
			if (xfer_hold_r && span_set) begin
				word_pending_flag <= 1'b1;
			end else if (buffer_clear_strobe && !halt_detector
				&& !instr_word[C_DIR]) begin
				word_pending_flag <= 1'b1;
			end else if (buffer_set_strobe && instr_word[C_DIR]) begin
				word_pending_flag <= 1'b0;
			end else if (prec && span_clr && cnt == 2'h0) begin
				word_pending_flag <= 1'b0;
			end
		end
	end

	// transfer: exchange C and word register, one pulse at T0
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			xfer_hold_r <= 1'b0;
			xfer_done <= 1'b0;
			c_out_word <= WORD_RST;
		end else if (clk_en) begin
			xfer_done <= xfer_hold_r && t0;
			if (xfer_take) begin
				xfer_hold_r <= 1'b1;
				c_out_word <= word_assembly_reg_r;
			end else if (t0) begin
				xfer_hold_r <= 1'b0;
			end
		end
	end

	// word register: loaded by transfer, rotated through characters
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			word_assembly_reg_r <= WORD_RST;
		end else if (clk_en) begin
			if (xfer_take) begin
				word_assembly_reg_r <= c_in_word;
			end else if (prec && t0) begin
				word_assembly_reg_r <= {word_assembly_reg_r[CHAR_TOP-1:0],
					char_shift_reg_r};
			end
		end
	end

	// character register and parity flop
	// input parity is checked serially so the flop ends odd when good
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			char_shift_reg_r <= CHAR_RST;
			parity_flop_r <= 1'b0;
		end else if (clk_en) begin
			if (buffer_clear_strobe) begin
				char_shift_reg_r <= CHAR_RST;
				parity_flop_r <= 1'b0;
			end else if (prec && t0) begin
				char_shift_reg_r <= word_assembly_reg_r[WORD_W-1:CHAR_TOP];
				if (direction_bit) begin
					parity_flop_r <= ~^word_assembly_reg_r[WORD_W-1:CHAR_TOP];
				end
			end else if (prec && span_clr && !direction_bit) begin
				parity_flop_r <= parity_flop_r
					^ char_shift_reg_r[3'(slot_r - SLOT_T17)];
			end else if (!direction_bit && !clock_seen_r
				&& !precess_request_r && !precess_gate_r) begin
				char_shift_reg_r <= CHAR_RST;
				parity_flop_r <= 1'b0;
			end else if (!direction_bit && clock_seen_r
				&& !precess_request_r) begin
				// a late unload leaves the held character untouched
				char_shift_reg_r <= char_shift_reg_r | zw;
				parity_flop_r <= parity_flop_r | pin_lvl_r[6];
			end
		end
	end

	// active flag: set by start, dropped by the stop command
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_flag <= 1'b0;
		end else if (clk_en) begin
			if (stop_cmd) begin
				active_flag <= 1'b0;
			end else if (buffer_set_strobe) begin
				active_flag <= 1'b1;
			end
		end
	end

	// error flop, read by the skip test; setting wins over clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			error_flag <= 1'b0;
		end else if (clk_en) begin
			if (tp && active_flag && !clock_seen_r
				&& precess_request_r && ecw) begin
				error_flag <= 1'b1;
			end else if (prec && span_set && !direction_bit
				&& !parity_flop_r && !halt_detector) begin
				error_flag <= 1'b1;
			end else if (buffer_clear_strobe && !halt_detector) begin
				error_flag <= 1'b0;
			end
		end
	end

	// service request when full on input or empty on output
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			service_irq <= 1'b0;
		end else if (clk_en) begin
			service_irq <= !word_pending_flag && active_flag
				&& !halt_detector && !xfer_hold_r;
		end
	end

	// stored input words queue toward the processor side
	word_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_word_fifo (
		.clock     (clock),
		.rst       (rst),
		.clk_en    (clk_en),
		.in_valid  (xfer_take && !direction_bit),
		.in_ready  (fifo_in_ready),
		.in_data   (word_assembly_reg_r),
		.out_valid (word_out_valid),
		.out_ready (word_out_ready),
		.out_data  (word_out_data)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_start_addr: assert property (clk_en && buffer_set_strobe |=>
		unit_address == $past(instr_word[C_UA_LO:C_UA_HI]))
		else $error("unit address not loaded");
	chk_start_dir: assert property (clk_en && buffer_set_strobe |=>
		direction_bit == $past(instr_word[C_DIR]))
		else $error("direction not loaded");
	chk_start_count: assert property (clk_en && buffer_set_strobe |=>
		cnt == {$past(instr_word[C_CNT_LO]), $past(instr_word[C_CNT_HI])})
		else $error("count not loaded");
	chk_clear_first: assert property (clk_en && buffer_clear_strobe |=>
		!direction_bit && cnt == 2'h0 && unit_address == UNIT_RST)
		else $error("start clear missed");
	chk_count_dec: assert property (clk_en && prec && t0
		&& cnt != 2'h0 |=> cnt == $past(cnt) - 2'h1)
		else $error("counter did not decrement");
	chk_gate_off: assert property (clk_en && prec && t0 |=>
		!precess_gate_r) else $error("gate past T0");
	chk_no_precess: assert property (clk_en && t24 &&
		!word_pending_flag |=> !precess_gate_r)
		else $error("precession while not pending");
	chk_count_field: assert property (clk_en && prec |=>
		war_cnt_r == $past(war_cnt_r)) else $error("count field changed");
	chk_late_error: assert property (clk_en && tp && active_flag
		&& !clock_seen_r && precess_request_r && ecw |=> error_flag)
		else $error("late service not flagged");
	chk_irq_block: assert property (clk_en && !active_flag |=>
		!service_irq) else $error("request while inactive");
	chk_xfer_done: assert property (clk_en && xfer_take |->
		##[1:30] xfer_done) else $error("transfer never done");

	cov_start: cover property (clk_en && buffer_set_strobe && t0);
	cov_precess: cover property (clk_en && prec && t0);
	cov_xfer: cover property (xfer_done);
	cov_late: cover property (clk_en && tp && precess_request_r && ecw);
endmodule

//--- link_peripheral_model.sv
/*
 * Peripheral model: sends one 6-bit character and its parity bit per
 * rising edge of go, framed by one character clock pulse.
 * Assumes the bench raises go only while busy is low.
 */
`timescale 1ns/100ps
module link_peripheral_model (
	input  wire logic       go,
	input  wire logic [5:0] ch,
	input  wire logic       par,
	output logic            char_clock,
	output logic [5:0]      char_in,
	output logic            char_in_parity,
	output logic            busy
);
	localparam real TICK = 64.0;

	// idle: clock parked low, data lines at an arbitrary pattern
	initial begin
		char_clock = 1'h0;
		{char_in, char_in_parity} = 7'h55;
		busy = 1'h0;
	end

	// one frame; the odd offset keeps edges off the bench clock phase
	always @(posedge go) begin
		busy = 1'h1;
		#1.3;
		{char_in, char_in_parity} = {ch, par};
		#TICK char_clock = 1'h1;
		#(4 * TICK) char_clock = 1'h0;
		// data kept long after the fall so the gating window is covered
		#(8 * TICK) {char_in, char_in_parity} = ~{ch, par};
		busy = 1'h0;
	end
endmodule

//--- tb_top.sv
/*
 * Self-checking bench for the character/word buffer and its word FIFO.
 * Assumes clk_en held high, so one clock cycle is one pulse time.
 */
`timescale 1ns/100ps
module tb_top
	import char_buf_pkg::*;
;
	localparam logic [23:0] ZERO = 24'h00_0000;
	localparam logic [23:0] ONE  = 24'h00_0001;
	logic              clock, rst, clk_en, io_start_instr, stop_cmd;
	logic              word_transfer_cmd, halt_detector, word_out_ready;
	logic              char_clock, char_in_parity, char_out_parity, go;
	logic              par, busy, xfer_done, service_irq, error_flag;
	logic              direction_bit, active_flag, word_pending_flag;
	logic              word_out_valid;
	logic [0:WORD_W-1] instr_word;
	logic [WORD_W-1:0] c_in_word, c_out_word, word_out_data;
	logic [CHAR_W-1:0] char_in, char_out, ch;
	logic [UNIT_W-1:0] unit_address;
	int                errors, tests_run, cnt;

	char_word_buffer u_char_word_buffer (
		.clock(clock), .rst(rst), .clk_en(clk_en),
		.io_start_instr(io_start_instr), .instr_word(instr_word),
		.word_transfer_cmd(word_transfer_cmd), .c_in_word(c_in_word),
		.stop_cmd(stop_cmd), .halt_detector(halt_detector),
		.char_clock(char_clock), .char_in(char_in),
		.char_in_parity(char_in_parity), .word_out_ready(word_out_ready),
		.char_out(char_out), .char_out_parity(char_out_parity),
		.c_out_word(c_out_word), .xfer_done(xfer_done),
		.service_irq(service_irq), .error_flag(error_flag),
		.unit_address(unit_address), .direction_bit(direction_bit),
		.active_flag(active_flag), .word_pending_flag(word_pending_flag),
		.word_out_valid(word_out_valid), .word_out_data(word_out_data)
	);
	link_peripheral_model u_link_peripheral_model (
		.go(go), .ch(ch), .par(par), .char_clock(char_clock),
		.char_in(char_in), .char_in_parity(char_in_parity), .busy(busy)
	);

	// free-running 200 MHz clock
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	// edge count since reset: while the count is a multiple of 26 the slot is Tp
	always @(posedge clock or posedge rst) begin
		if (rst) cnt <= 0;
		else if (clk_en) cnt <= cnt + 1;
	end

	// report, verdict and end of run
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic hang();
		errors++;
		wrap_up();
	endtask

	task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h",
				$time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		check_val({23'h00_0000, got}, {23'h00_0000, exp});
	endtask

	function automatic logic odd(input logic [5:0] c);
		return ~^c;
	endfunction

	// start word: unit address, direction, count pair, buffer select
	function automatic logic [0:23] mk(input logic [4:0] ua,
		input logic d, input logic c15, input logic c16, input logic sel);
		logic [0:23] w;
		w = ZERO;
		w[C_UA_LO +: UNIT_W] = ua;
		w[C_DIR] = d;
		w[C_SEL] = sel;
		w[C_CNT_HI] = c16;
		w[C_CNT_LO] = c15;
		return w;
	endfunction

	// start held over one whole machine cycle, then one cycle to settle
	task automatic start(input logic [0:23] w);
		int g;
		for (g = 0; g < 30 && cnt % 26 != 0; g++) @(negedge clock);
		if (g == 30) hang();
		instr_word = w;
		io_start_instr = 1'h1;
		repeat (26) @(negedge clock);
		io_start_instr = 1'h0;
		repeat (26) @(negedge clock);
	endtask

	task automatic send(input logic [5:0] c, input logic p);
		int g;
		ch = c;
		par = p;
		go = 1'h1;
		@(negedge clock);
		go = 1'h0;
		for (g = 0; g < 400 && busy === 1'h1; g++) @(negedge clock);
		if (g == 400) hang();
	endtask

	// command held until xfer_done; a refused one stays raised
	task automatic xfer(input logic [23:0] d, input logic must,
		output logic ok);
		int g;
		c_in_word = d;
		word_transfer_cmd = 1'h1;
		ok = 1'h0;
		for (g = 0; g < 200 && !ok; g++) begin
			@(negedge clock);
			ok = (xfer_done === 1'h1);
		end
		if (ok) word_transfer_cmd = 1'h0;
		else if (must) hang();
	endtask

	task automatic t_reset();
		check_val({char_out, char_out_parity, unit_address, 12'h000}, ZERO);
		check_val({16'h0000, xfer_done, service_irq, error_flag, direction_bit,
			active_flag, word_pending_flag, word_out_valid, 1'h0}, ZERO);
		check_val(c_out_word | word_out_data, ZERO);
	endtask

	// a second start must clear before loading; select bit one is ignored
	task automatic t_fields();
		start(mk(5'h1f, 1'h1, 1'h0, 1'h0, 1'h0));
		check_val({19'h0_0000, unit_address}, 24'h00_001f);
		check_flag(direction_bit, 1'h1);
		check_flag(active_flag, 1'h1);
		start(mk(5'h0a, 1'h0, 1'h0, 1'h0, 1'h0));
		check_val({19'h0_0000, unit_address}, 24'h00_000a);
		check_flag(direction_bit, 1'h0);
		start(mk(5'h15, 1'h1, 1'h0, 1'h0, 1'h1));
		check_val({19'h0_0000, unit_address}, 24'h00_000a);
		check_flag(direction_bit, 1'h0);
	endtask

	// every count code, two words each, so the reload is exercised too
	task automatic t_counts();
		logic [23:0] exp;
		logic [24:0] m;
		logic [5:0]  c;
		logic        ok;
		int          n, i, w;
		for (n = 1; n <= 4; n++) begin
			start(mk(5'h03, 1'h0, n >= 3, n == 2 || n == 4, 1'h0));
			check_flag(word_pending_flag, 1'h1);
			m = (25'h000_0001 << (6 * n)) - 25'h000_0001;
			for (w = 0; w < 2; w++) begin
				exp = ZERO;
				for (i = 0; i < n; i++) begin
					c = 6'(n * 8 + w * 3 + i * 5 + 1);
					send(c, odd(c));
					exp = {exp[17:0], c};
					check_flag(word_pending_flag, i < n - 1);
					check_flag(service_irq, i == n - 1);
					check_val({18'h0_0000, char_out}, ZERO);
				end
				xfer(ZERO, 1'h1, ok);
				check_val(c_out_word & m[23:0], exp & m[23:0]);
				check_flag(word_pending_flag, 1'h1);
			end
		end
	endtask

	task automatic t_parity();
		start(mk(5'h07, 1'h0, 1'h0, 1'h0, 1'h0));
		check_flag(error_flag, 1'h0);
		send(6'h03, 1'h0);
		check_flag(error_flag, 1'h1);
	endtask

	// a start while halted keeps the error and leaves pending clear
	task automatic t_halt();
		halt_detector = 1'h1;
		start(mk(5'h07, 1'h0, 1'h0, 1'h0, 1'h0));
		check_flag(error_flag, 1'h1);
		check_flag(word_pending_flag, 1'h0);
		halt_detector = 1'h0;
		start(mk(5'h07, 1'h0, 1'h0, 1'h0, 1'h0));
		check_flag(error_flag, 1'h0);
		check_flag(word_pending_flag, 1'h1);
	endtask

	task automatic t_stop();
		start(mk(5'h07, 1'h0, 1'h0, 1'h0, 1'h0));
		send(6'h01, 1'h0);
		check_flag(service_irq, 1'h1);
		stop_cmd = 1'h1;
		repeat (26) @(negedge clock);
		stop_cmd = 1'h0;
		check_flag(active_flag, 1'h0);
		check_flag(service_irq, 1'h0);
		send(6'h02, 1'h0);
		send(6'h04, 1'h0);
		check_flag(error_flag, 1'h0);
	endtask

	// word left unloaded: one more character held, the next one is late
	task automatic t_late();
		start(mk(5'h07, 1'h0, 1'h0, 1'h0, 1'h0));
		send(6'h01, 1'h0);
		send(6'h2c, 1'h0);
		check_val({18'h0_0000, char_out}, 24'h00_002c);
		send(6'h04, 1'h0);
		check_flag(error_flag, 1'h1);
		check_flag(service_irq, 1'h1);
	endtask

	task automatic t_output();
		logic [23:0] d;
		logic [6:0]  e;
		logic        ok;
		int          i;
		d = 24'hc3_5000;
		start(mk(5'h05, 1'h1, 1'h0, 1'h1, 1'h0));
		check_flag(word_pending_flag, 1'h0);
		check_flag(service_irq, 1'h1);
		xfer(d, 1'h1, ok);
		check_flag(service_irq, 1'h0);
		for (i = 0; i < 2; i++) begin
			send(6'h00, 1'h0);
			e = {d[23:18], odd(d[23:18])};
			check_val({17'h0_0000, char_out, char_out_parity}, {17'h0_0000, e});
			d = d << 6;
		end
		check_flag(service_irq, 1'h1);
	endtask

	// fill the word FIFO with the drain stalled, then empty it
	task automatic t_fifo();
		logic ok;
		int   k, g;
		word_out_ready = 1'h0;
		start(mk(5'h07, 1'h0, 1'h0, 1'h0, 1'h0));
		for (k = 0; k < 17; k++) begin
			send(6'(k * 3 + 1), odd(6'(k * 3 + 1)));
			xfer(ZERO, k < 16, ok);
		end
		check_flag(ok, 1'h0);
		check_val(word_out_data & 24'h00_003f, ONE);
		word_out_ready = 1'h1;
		@(negedge clock);
		word_out_ready = 1'h0;
		xfer(ZERO, 1'h1, ok);
		word_out_ready = 1'h1;
		k = 1;
		// look at the head before each edge, since that edge consumes it
		for (g = 0; g < 64; g++) begin
			if (word_out_valid === 1'h1) begin
				check_val(word_out_data & 24'h00_003f, 24'(k * 3 + 1));
				k++;
			end
			@(negedge clock);
		end
		check_val(24'(k), 24'h00_0011);
		check_flag(word_out_valid, 1'h0);
	endtask

	// main sequence
	initial begin
		{rst, clk_en, io_start_instr, stop_cmd, word_transfer_cmd,
			halt_detector, word_out_ready, go, par} = 9'h184;
		instr_word = ZERO;
		c_in_word = ZERO;
		ch = 6'h00;
		errors = 0;
		tests_run = 0;
		repeat (4) @(negedge clock);
		rst = 1'h0;
		t_reset();
		t_fields();
		t_counts();
		t_parity();
		t_halt();
		t_stop();
		t_late();
		t_output();
		t_fifo();
		wrap_up();
	end
endmodule
